// ==== hpsfc_pkg.sv ====
// Package of constants and types for the host port and timing control block
// Overview of operation
// - Timing pulse out delayed by pipeline depth plus two sync stages
// - Tri-level input honoured only when enabled
// - Tri-level low drives enabled outputs' level
// - One ten-bit bidirectional host data bus
// - Bus modes: 10-bit, 8+2, plain 8-bit
// - Field parity used only when interlaced
// - Odd and even fields strictly alternate
// - Write data captured at chip select rise
// - Read/write select picks access direction
// - Write when read/write and select low
// - Read when read/write high, select low
// - Command select chooses operation type
// - Command select latched at select fall
// - Timing reaches channel only when enabled
package hpsfc_pkg;
   localparam int          DATA_W        = 10;
   localparam int          PIPE_DEPTH    = 8;
   localparam int          CMD_W         = 2;
   localparam int          PTR_W         = 8;
   localparam int          CTL_REGS      = 8;
   localparam int          CTL_AW        = 3;
   // Command select codes
   localparam logic [1:0]  CMD_ADDR      = 2'h0;
   localparam logic [1:0]  CMD_PALETTE   = 2'h1;
   localparam logic [1:0]  CMD_CTRL      = 2'h2;
   localparam logic [1:0]  CMD_EXTRA     = 2'h3;
   // Bus width modes
   localparam logic [1:0]  BUS_10        = 2'h0;
   localparam logic [1:0]  BUS_8P2       = 2'h1;
   localparam logic [1:0]  BUS_8         = 2'h2;
   // Control register indices and bit positions
   localparam logic [2:0]  CR1_IDX       = 3'h1;
   localparam logic [2:0]  CR2_IDX       = 3'h2;
   localparam logic [2:0]  CR4_IDX       = 3'h4;
   localparam int          TRI_EN_POS    = 7;
   localparam int          GRN_EN_POS    = 2;
   localparam int          RED_EN_POS    = 1;
   localparam int          BLU_EN_POS    = 2;
   localparam int          BUSMODE_POS   = 0;
   localparam int          INTERLACE_POS = 3;
   localparam logic [9:0]  CTL_RESET     = 10'h000;
   // Output level codes per channel
   typedef enum logic [1:0] {
      HPSFC_LVL_VIDEO,
      HPSFC_LVL_BLANK,
      HPSFC_LVL_SYNC,
      HPSFC_LVL_TRI
   } hpsfc_level_t;
   typedef enum logic [1:0] {
      HPSFC_IDLE,
      HPSFC_ACCESS,
      HPSFC_DONE
   } hpsfc_state_t;

   // Byte-lane merge for the 8+2 and 8-bit modes
   function automatic logic [9:0] hpsfc_merge(input logic [1:0] mode,
                                              input logic       hi,
                                              input logic [9:0] old,
                                              input logic [9:0] bus);
      logic [9:0] r;
      r = bus;
      if (mode == BUS_8P2) begin
         r = hi ? {bus[1:0], old[7:0]} : {old[9:8], bus[7:0]};
      end else if (mode == BUS_8) begin
         r = {2'h0, bus[7:0]};
      end
      return r;
   endfunction : hpsfc_merge
endpackage : hpsfc_pkg

// ==== hpsfc_mem_if.sv ====
// Interface between the host port and its palette memory
`timescale 1ns/1ps
`default_nettype none
interface hpsfc_mem_if;
   logic       we;
   logic [7:0] addr;
   logic [9:0] wdata;
   logic [9:0] rdata;
   modport ctl (output we, output addr, output wdata, input rdata);
   modport mem (input we, input addr, input wdata, output rdata);
endinterface : hpsfc_mem_if
`default_nettype wire

// ==== hpsfc_palette.sv ====
// Palette memory, 256 words of ten bits, registered read
`timescale 1ns/1ps
`default_nettype none
module hpsfc_palette (
   input  wire logic   i_mclk,
   hpsfc_mem_if.mem    mem
);
   logic [9:0] store [256];
   logic [9:0] rd;

   // Registered read keeps the host path timing simple
   always_ff @(posedge i_mclk) begin
      if (mem.we) begin
         store[mem.addr] <= mem.wdata;
      end
      rd <= store[mem.addr];
   end
   assign mem.rdata = rd;
endmodule : hpsfc_palette
`default_nettype wire

// ==== hpsfc_top.sv ====
// Host port, timing pulse pipeline and field tracking
`timescale 1ns/1ps
`default_nettype none
module hpsfc_top (
   input  wire logic                     i_mclk,
   input  wire logic                     i_rst,
   input  wire logic                     i_chip_sel_n,
   input  wire logic                     i_read_write,
   input  wire logic [hpsfc_pkg::CMD_W-1:0] i_host_command_select,
   input  wire logic [hpsfc_pkg::DATA_W-1:0] i_host_data_bus,
   output logic [hpsfc_pkg::DATA_W-1:0]  o_host_data_bus,
   output logic                          o_host_data_bus_oe,
   input  wire logic                     i_timing_pulse_n,
   input  wire logic                     i_picture_off_n,
   input  wire logic                     i_hdtv_tri_level_ctl_n,
   input  wire logic                     i_field_parity,
   output logic                          o_delayed_timing_pulse_out_n,
   output hpsfc_pkg::hpsfc_level_t       o_red_level,
   output hpsfc_pkg::hpsfc_level_t       o_green_level,
   output hpsfc_pkg::hpsfc_level_t       o_blue_level,
   output logic                          o_odd_field,
   output logic                          o_field_error
);
   import hpsfc_pkg::*;

   // Two-stage synchronisers for all pin inputs
   logic [7:0] s1;
   logic [7:0] s2;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         s1 <= 8'hFF;
         s2 <= 8'hFF;
      end else begin
         s1 <= {i_chip_sel_n, i_read_write, i_host_command_select,
                i_timing_pulse_n, i_picture_off_n,
                i_hdtv_tri_level_ctl_n, i_field_parity};
         s2 <= s1;
      end
   end
   logic       cs_n;
   logic       rw;
   logic [1:0] cmd_pin;
   logic       tp_n;
   logic       blank_n;
   logic       tri_n;
   logic       parity;
   assign cs_n    = s2[7];
   assign rw      = s2[6];
   assign cmd_pin = s2[5:4];
   assign tp_n    = s2[3];
   assign blank_n = s2[2];
   assign tri_n   = s2[1];
   assign parity  = s2[0];

   // Data bus is sampled twice too; stable while chip select is low
   logic [9:0] d1;
   logic [9:0] d2;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         d1 <= 10'h000;
         d2 <= 10'h000;
      end else begin
         d1 <= i_host_data_bus;
         d2 <= d1;
      end
   end

   // Host access state
   hpsfc_state_t state;
   hpsfc_state_t next_state;
   logic         cs_q;
   logic [1:0]   cmd;
   logic [1:0]   next_cmd;
   logic         rw_q;
   logic         next_rw_q;
   logic [7:0]   ptr;
   logic [7:0]   next_ptr;
   logic         hi;
   logic         next_hi;
   logic [9:0]   ctl [CTL_REGS];
   logic [9:0]   next_ctl [CTL_REGS];
   logic [9:0]   extra;
   logic [9:0]   next_extra;
   logic [9:0]   pal_hold;
   logic [9:0]   next_pal_hold;
   logic [9:0]   rdata;
   logic [9:0]   next_rdata;
   logic         oe;
   logic         next_oe;
   logic         fall;
   logic         rise;
   logic [1:0]   mode;
   logic [9:0]   rd_word;

   hpsfc_mem_if  mif ();
   hpsfc_palette u_pal (
      .i_mclk (i_mclk),
      .mem    (mif)
   );

   assign fall = cs_q & ~cs_n;
   assign rise = ~cs_q & cs_n;
   assign mode = ctl[CR1_IDX][BUSMODE_POS +: 2];

   // Read data for the currently latched target
   function automatic logic [9:0] rd_sel(input logic [1:0] c,
                                         input logic [7:0] p,
                                         input logic [9:0] pal,
                                         input logic [9:0] cr,
                                         input logic [9:0] ex);
      logic [9:0] r;
      r = 10'h000;
      case (c)
         CMD_ADDR:    r = {2'h0, p};
         CMD_PALETTE: r = pal;
         CMD_CTRL:    r = cr;
         CMD_EXTRA:   r = ex;
         default:     r = 10'h000;
      endcase
      return r;
   endfunction : rd_sel
   assign rd_word = rd_sel(cmd, ptr, mif.rdata, ctl[ptr[CTL_AW-1:0]],
                           extra);

   // Next-state logic of the host port
   always_comb begin
      next_state    = state;
      next_cmd      = cmd;
      next_rw_q     = rw_q;
      next_ptr      = ptr;
      next_hi       = hi;
      next_extra    = extra;
      next_pal_hold = pal_hold;
      next_rdata    = rdata;
      next_oe       = oe;
      for (int k = 0; k < CTL_REGS; k++) begin
         next_ctl[k] = ctl[k];
      end
      mif.we    = 1'b0;
      mif.addr  = ptr;
      mif.wdata = pal_hold;
      case (state)
         HPSFC_IDLE: begin
            if (fall) begin
               next_cmd   = cmd_pin;
               next_rw_q  = rw;
               next_state = HPSFC_ACCESS;
            end
         end
         HPSFC_ACCESS: begin
            // Read drives the bus only with select low and rw high
            next_oe    = rw_q & ~cs_n;
            next_rdata = rd_word;
            if (mode == BUS_8P2 && hi) begin
               next_rdata = {8'h00, rd_word[9:8]};
            end else if (mode != BUS_10) begin
               next_rdata = {2'h0, rd_word[7:0]};
            end
            if (rise) begin
               next_oe    = 1'b0;
               next_state = HPSFC_DONE;
               if (!rw_q) begin
                  // Write taken at chip select rise
                  case (cmd)
                     CMD_ADDR: begin
                        next_ptr = d2[7:0];
                        next_hi  = 1'b0;
                     end
                     CMD_PALETTE: begin
                        next_pal_hold = hpsfc_merge(mode, hi, pal_hold,
                                                    d2);
                     end
                     CMD_CTRL: begin
                        next_ctl[ptr[CTL_AW-1:0]] = d2;
                     end
                     CMD_EXTRA: begin
                        next_extra = d2;
                     end
                     default: begin
                        next_extra = extra;
                     end
                  endcase
               end
            end
         end
         HPSFC_DONE: begin
            next_state = HPSFC_IDLE;
            if (cmd == CMD_PALETTE) begin
               // 8+2 pairs two accesses, low byte first
               if (mode == BUS_8P2 && !hi) begin
                  next_hi = 1'b1;
               end else begin
                  next_hi  = 1'b0;
                  mif.we   = ~rw_q;
                  next_ptr = 8'(ptr + 8'h01);
               end
            end
         end
         default: begin
            next_state = HPSFC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state    <= HPSFC_IDLE;
         cs_q     <= 1'b1;
         cmd      <= CMD_ADDR;
         rw_q     <= 1'b1;
         ptr      <= 8'h00;
         hi       <= 1'b0;
         extra    <= 10'h000;
         pal_hold <= 10'h000;
         rdata    <= 10'h000;
         oe       <= 1'b0;
         for (int k = 0; k < CTL_REGS; k++) begin
            ctl[k] <= CTL_RESET;
         end
      end else begin
         state    <= next_state;
         cs_q     <= cs_n;
         cmd      <= next_cmd;
         rw_q     <= next_rw_q;
         ptr      <= next_ptr;
         hi       <= next_hi;
         extra    <= next_extra;
         pal_hold <= next_pal_hold;
         rdata    <= next_rdata;
         oe       <= next_oe;
         for (int k = 0; k < CTL_REGS; k++) begin
            ctl[k] <= next_ctl[k];
         end
      end
   end
   assign o_host_data_bus    = rdata;
   assign o_host_data_bus_oe = oe;

   // Timing pulse pipeline, matches pixel path depth
   logic [PIPE_DEPTH-1:0] pipe;
   logic [PIPE_DEPTH-1:0] next_pipe;
   logic                  tri_act;
   logic                  next_tri_act;
   always_comb begin
      next_pipe    = {pipe[PIPE_DEPTH-2:0], tp_n};
      // Source keeps tri-level inside blanking; gated anyway
      next_tri_act = ctl[CR1_IDX][TRI_EN_POS] & ~tri_n
                   & ~blank_n;
   end
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pipe    <= {PIPE_DEPTH{1'b1}};
         tri_act <= 1'b0;
      end else begin
         pipe    <= next_pipe;
         tri_act <= next_tri_act;
      end
   end
   assign o_delayed_timing_pulse_out_n = pipe[PIPE_DEPTH-1];

   // Per-channel level from blank, timing and tri-level
   function automatic hpsfc_level_t lvl(input logic en,
                                        input logic blk_n,
                                        input logic t_n,
                                        input logic tri_on);
      hpsfc_level_t r;
      r = HPSFC_LVL_VIDEO;
      if (en && tri_on) begin
         r = HPSFC_LVL_TRI;
      end else if (en && !t_n) begin
         r = HPSFC_LVL_SYNC;
      end else if (!blk_n) begin
         r = HPSFC_LVL_BLANK;
      end
      return r;
   endfunction : lvl

   hpsfc_level_t next_red;
   hpsfc_level_t next_grn;
   hpsfc_level_t next_blu;
   always_comb begin
      next_red = lvl(ctl[CR4_IDX][RED_EN_POS], blank_n, tp_n, tri_act);
      next_grn = lvl(ctl[CR2_IDX][GRN_EN_POS], blank_n, tp_n, tri_act);
      next_blu = lvl(ctl[CR4_IDX][BLU_EN_POS], blank_n, tp_n, tri_act);
   end
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_red_level   <= HPSFC_LVL_BLANK;
         o_green_level <= HPSFC_LVL_BLANK;
         o_blue_level  <= HPSFC_LVL_BLANK;
      end else begin
         o_red_level   <= next_red;
         o_green_level <= next_grn;
         o_blue_level  <= next_blu;
      end
   end

   // Field tracking; parity read only at vertical blank in interlace
   logic par_q;
   logic next_par_q;
   logic odd;
   logic next_odd;
   logic ferr;
   logic next_ferr;
   logic ilace;
   assign ilace = ctl[CR1_IDX][INTERLACE_POS];
   always_comb begin
      next_par_q = parity;
      next_odd   = odd;
      next_ferr  = ferr;
      if (!ilace) begin
         next_odd  = 1'b0;
         next_ferr = 1'b0;
      end else if (!blank_n && parity != par_q) begin
         // Fields assumed to alternate; a repeat flags an error
         next_odd  = ~odd;
         next_ferr = (parity == odd);
      end
   end
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         par_q <= 1'b0;
         odd   <= 1'b0;
         ferr  <= 1'b0;
      end else begin
         par_q <= next_par_q;
         odd   <= next_odd;
         ferr  <= next_ferr;
      end
   end
   assign o_odd_field   = odd;
   assign o_field_error = ferr;
endmodule : hpsfc_top
`default_nettype wire

// ==== hpsfc_top_assertions.sv ====
// Assertions on the host port and timing pins of the block
`timescale 1ns/1ps
`default_nettype none
module hpsfc_chk (
   input  wire logic                    i_mclk,
   input  wire logic                    i_rst,
   input  wire logic                    i_chip_sel_n,
   input  wire logic                    i_read_write,
   input  wire logic                    i_timing_pulse_n,
   input  wire logic                    i_picture_off_n,
   input  wire logic                    i_hdtv_tri_level_ctl_n,
   input  wire logic                    o_host_data_bus_oe,
   input  wire logic                    o_delayed_timing_pulse_out_n,
   input  wire hpsfc_pkg::hpsfc_level_t o_red_level,
   input  wire hpsfc_pkg::hpsfc_level_t o_green_level,
   input  wire hpsfc_pkg::hpsfc_level_t o_blue_level
);
   import hpsfc_pkg::*;
   logic [3:0] up;
   logic [3:0] next_up;
   // Cycles since reset, so history checks skip reset leftovers
   always_comb next_up = (up == 4'hF) ? up : up + 4'h1;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) up <= 4'h0;
      else up <= next_up;
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   chk_pulse_delay: assert property (up > 4'hA |->
      o_delayed_timing_pulse_out_n == $past(i_timing_pulse_n, 10))
      else $error("delayed pulse wrong");
   chk_read_drive: assert property (
      $fell(i_chip_sel_n) && i_read_write |-> ##[2:8] o_host_data_bus_oe)
      else $error("read not driven");
   chk_write_quiet: assert property (
      $fell(i_chip_sel_n) && !i_read_write |-> !o_host_data_bus_oe [*8])
      else $error("write drives bus");
   chk_oe_release: assert property ($rose(i_chip_sel_n) |->
      ##[1:6] !o_host_data_bus_oe) else $error("bus held after select");
   chk_oe_idle: assert property (i_chip_sel_n [*8] |->
      !o_host_data_bus_oe) else $error("bus driven while idle");
   chk_tri_cause: assert property (o_green_level == HPSFC_LVL_TRI |->
      !$past(i_hdtv_tri_level_ctl_n, 4)) else $error("tri level uncaused");
   chk_sync_cause: assert property (o_red_level == HPSFC_LVL_SYNC |->
      !$past(i_timing_pulse_n, 3)) else $error("sync level uncaused");
   chk_video_open: assert property (up > 4'h4 &&
      $past(i_picture_off_n, 3) && $past(i_picture_off_n, 4) |->
      o_blue_level == HPSFC_LVL_VIDEO) else $error("video level missing");
   // Main scenarios reached
   cov_read: cover property ($fell(i_chip_sel_n) && i_read_write);
   cov_tri: cover property (o_green_level == HPSFC_LVL_TRI);
   cov_sync: cover property (o_red_level == HPSFC_LVL_SYNC);
endmodule : hpsfc_chk
bind hpsfc_top hpsfc_chk u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_chip_sel_n(i_chip_sel_n), .i_read_write(i_read_write),
   .i_timing_pulse_n(i_timing_pulse_n), .i_picture_off_n(i_picture_off_n),
   .i_hdtv_tri_level_ctl_n(i_hdtv_tri_level_ctl_n),
   .o_host_data_bus_oe(o_host_data_bus_oe),
   .o_delayed_timing_pulse_out_n(o_delayed_timing_pulse_out_n),
   .o_red_level(o_red_level), .o_green_level(o_green_level),
   .o_blue_level(o_blue_level));
`default_nettype wire

// ==== hpsfc_host_model.sv ====
// Host processor model driving the select-strobed data port
`timescale 1ns/1ps
`default_nettype none
module hpsfc_host (
   input  wire logic       i_mclk,
   input  wire logic [9:0] i_bus,
   output logic            o_chip_sel_n,
   output logic            o_read_write,
   output logic [1:0]      o_cmd,
   output logic [9:0]      o_data,
   output logic            o_data_oe
);
   // Idle host: select high, bus released
   initial begin
      o_chip_sel_n = 1'b1;
      o_read_write = 1'b1;
      o_cmd = 2'h0;
      o_data = 10'h000;
      o_data_oe = 1'b0;
   end
   // One access, long enough for the two-stage select sync
   task automatic access(input logic rw, input logic [1:0] c,
                         input logic [9:0] d, output logic [9:0] r);
      @(negedge i_mclk);
      o_read_write = rw;
      o_cmd = c;
      o_data = d;
      o_data_oe = !rw;
      o_chip_sel_n = 1'b0;
      repeat (6) @(negedge i_mclk);
      o_cmd = ~c;
      repeat (2) @(negedge i_mclk);
      r = i_bus;
      o_chip_sel_n = 1'b1;
      // Data held past the synced rise, then let go
      repeat (4) @(negedge i_mclk);
      o_data_oe = 1'b0;
      repeat (6) @(negedge i_mclk);
   endtask : access
endmodule : hpsfc_host
`default_nettype wire

// ==== hpsfc_top_tb.sv ====
// Self-checking bench for the host port and timing block
`timescale 1ns/1ps
`default_nettype none
module hpsfc_top_tb;
   import hpsfc_pkg::*;
   logic         i_mclk = 1'b0;
   logic         i_rst = 1'b1;
   logic         tmg_n = 1'b1;
   logic         pic_n = 1'b0;
   logic         tri_n = 1'b1;
   logic         par = 1'b0;
   logic         cs_n, rw, h_oe, doe, dly, odd, ferr;
   logic [1:0]   cmd;
   logic [9:0]   h_d, d_out, bus;
   logic [9:0]   mem [4];
   logic [31:0]  seed = 32'h782577B7;
   hpsfc_level_t lr, lg, lb;
   int           mismatches = 0;
   int           checks_done = 0;
   // Clock, 40 ns period
   always #20 i_mclk = ~i_mclk;
   // Terminated bus floats high when nobody drives
   assign bus = h_oe ? h_d : (doe ? d_out : 10'h3FF);
   hpsfc_host host (.i_mclk(i_mclk), .i_bus(bus), .o_chip_sel_n(cs_n),
      .o_read_write(rw), .o_cmd(cmd), .o_data(h_d), .o_data_oe(h_oe));
   hpsfc_top DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_chip_sel_n(cs_n),
      .i_read_write(rw), .i_host_command_select(cmd),
      .i_host_data_bus(bus), .o_host_data_bus(d_out),
      .o_host_data_bus_oe(doe), .i_timing_pulse_n(tmg_n),
      .i_picture_off_n(pic_n), .i_hdtv_tri_level_ctl_n(tri_n),
      .i_field_parity(par), .o_delayed_timing_pulse_out_n(dly),
      .o_red_level(lr), .o_green_level(lg), .o_blue_level(lb),
      .o_odd_field(odd), .o_field_error(ferr));
   function automatic logic [9:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[9:0];
   endfunction : rnd
   // Expected steady level of one channel
   function automatic hpsfc_level_t lvl(logic p, logic s, logic t,
                                        logic en, logic te);
      if (p) return HPSFC_LVL_VIDEO;
      if (en && te && !t) return HPSFC_LVL_TRI;
      if (en && !s) return HPSFC_LVL_SYNC;
      return HPSFC_LVL_BLANK;
   endfunction : lvl
   task automatic cmp_word(input logic [9:0] g, input logic [9:0] e);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : cmp_word
   task automatic cmp_lvl(input hpsfc_level_t g, input hpsfc_level_t e);
      cmp_word({8'h00, g}, {8'h00, e});
   endtask : cmp_lvl
   task automatic wr(input logic [1:0] c, input logic [9:0] d);
      logic [9:0] r;
      host.access(1'b0, c, d, r);
   endtask : wr
   task automatic rd(input logic [1:0] c, input logic [9:0] e);
      logic [9:0] r;
      host.access(1'b1, c, 10'h000, r);
      cmp_word(r, e);
   endtask : rd
   task automatic setreg(input logic [2:0] i, input logic [9:0] v);
      wr(CMD_ADDR, {7'h00, i});
      wr(CMD_CTRL, v);
   endtask : setreg
   // Random six-cycle segments; pulses only inside blanking
   task automatic segs(input logic te, input int n);
      logic [9:0] r;
      logic       prev;
      prev = tmg_n;
      for (int k = 0; k < n; k++) begin
         r = rnd();
         @(negedge i_mclk);
         pic_n = r[0];
         tmg_n = r[0] | r[1];
         tri_n = r[0] | !r[1] | r[2];
         repeat (5) @(negedge i_mclk);
         cmp_lvl(lg, lvl(pic_n, tmg_n, tri_n, 1'b1, te));
         cmp_lvl(lr, lvl(pic_n, tmg_n, tri_n, 1'b1, te));
         cmp_lvl(lb, lvl(pic_n, tmg_n, tri_n, 1'b0, te));
         cmp_word({9'h0, dly}, {9'h0, prev});
         prev = tmg_n;
      end
   endtask : segs
   // Parity flips inside blanking, never repeating
   task automatic field(input logic il);
      logic o;
      @(negedge i_mclk);
      pic_n = 1'b0;
      tmg_n = 1'b1;
      tri_n = 1'b1;
      for (int k = 0; k < 4; k++) begin
         o = odd;
         @(negedge i_mclk);
         par = ~par;
         repeat (6) @(negedge i_mclk);
         cmp_word({9'h0, odd}, {9'h0, il ? ~o : o});
         cmp_word({9'h0, ferr}, 10'h000);
      end
   endtask : field
   task automatic report_and_stop();
      if (mismatches == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (4) @(posedge i_mclk);
      @(negedge i_mclk);
      cmp_word({9'h0, doe}, 10'h000);
      cmp_word({9'h0, dly}, 10'h001);
      cmp_lvl(lg, HPSFC_LVL_BLANK);
      i_rst = 1'b0;
      setreg(CR1_IDX, 10'h080);
      setreg(CR2_IDX, 10'h004);
      setreg(CR4_IDX, 10'h002);
      wr(CMD_ADDR, 10'h001);
      rd(CMD_CTRL, 10'h080);
      wr(CMD_ADDR, 10'h010);
      foreach (mem[k]) begin
         mem[k] = rnd();
         wr(CMD_PALETTE, mem[k]);
      end
      wr(CMD_ADDR, 10'h010);
      foreach (mem[k]) rd(CMD_PALETTE, mem[k]);
      wr(CMD_EXTRA, 10'h2C3);
      rd(CMD_EXTRA, 10'h2C3);
      // Byte mode drops the top bits; split mode pairs two writes
      setreg(CR1_IDX, 10'h082);
      wr(CMD_ADDR, 10'h020);
      wr(CMD_PALETTE, 10'h3A5);
      setreg(CR1_IDX, 10'h081);
      wr(CMD_ADDR, 10'h021);
      wr(CMD_PALETTE, 10'h15A);
      wr(CMD_PALETTE, 10'h3FE);
      wr(CMD_ADDR, 10'h021);
      rd(CMD_PALETTE, 10'h05A);
      rd(CMD_PALETTE, 10'h002);
      setreg(CR1_IDX, 10'h080);
      wr(CMD_ADDR, 10'h020);
      rd(CMD_PALETTE, 10'h0A5);
      rd(CMD_PALETTE, 10'h25A);
      segs(1'b1, 40);
      setreg(CR1_IDX, 10'h000);
      segs(1'b0, 40);
      setreg(CR1_IDX, 10'h088);
      field(1'b1);
      setreg(CR1_IDX, 10'h080);
      field(1'b0);
      report_and_stop();
   end
endmodule : hpsfc_top_tb
`default_nettype wire
